// ===== pattern_offset_margin_regs_tb.sv
`timescale 1ns/100ps
module pattern_offset_margin_regs_tb;
    import pom_pkg::*;
    logic        clock_i;
    logic        rst_i;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready, conv_valid_i, out_valid_o, margin_enable_o;
    logic [15:0] conv_result_i, out_word_o, pat;
    logic [2:0]  ref_range_o, rng;
    logic [4:0]  margin_offset_o, code;
    logic        dsel, en;
    int          fails, checks;
    logic [33:0] rd_q[$];
    logic [1:0]  wr_q[$];
    logic [24:0] dp_q[$];
    logic [11:0] map[6] = '{12'h040, 12'h050, 12'h054, 12'h058, 12'h080, 12'h0c0};

    pom_regs pom_regs_inst (
        .clock_i(clock_i), .rst_i(rst_i),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .conv_result_i(conv_result_i),
        .conv_valid_i(conv_valid_i), .out_word_o(out_word_o),
        .out_valid_o(out_valid_o), .ref_range_o(ref_range_o),
        .margin_enable_o(margin_enable_o), .margin_offset_o(margin_offset_o)
    );

    initial begin
        clock_i = 1'b0;
        forever #12.5 clock_i = ~clock_i;
    end

    task automatic chk(input string what, input logic [33:0] exp, input logic [33:0] got);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic final_report();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic timeout();
        fails++;
        $display("CHECK FAILED handshake expected done seen timeout");
        final_report();
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] resp);
        int n;
        @(posedge clock_i);
        n = 0;
        wr_q.push_back(resp);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clock_i);
            n++;
            if (n > 50) timeout();
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!(s_axi_bvalid && s_axi_bready));
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] resp);
        int n;
        @(posedge clock_i);
        n = 0;
        rd_q.push_back({resp, d});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clock_i);
            n++;
            if (n > 50) timeout();
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!(s_axi_rvalid && s_axi_rready));
        s_axi_rready <= 1'b0;
    endtask

    function automatic logic [31:0] shadow(input logic [11:0] a);
        case (a)
            12'h050: return {24'h0, pat[7:0]};
            12'h058: return {28'h0, pat[15:12]};
            12'h080: return {29'h0, rng};
            12'h0c0: return {26'h0, en, code};
            default: return 32'h0;
        endcase
    endfunction

    task automatic put(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] w;
        w = $urandom();
        w[7:0] = d;
        case (a)
            12'h040: dsel = d[0];
            12'h050: pat[7:0] = d;
            12'h058: pat[15:12] = d[3:0];
            12'h080: rng = d[2:0];
            12'h0c0: {en, code} = d[5:0];
            default: ;
        endcase
        wr(a, w, 4'hf, POM_RESP_OKAY);
    endtask

    task automatic conv(input logic [15:0] r);
        @(posedge clock_i);
        dp_q.push_back({dsel ? pat : r, (rng > 3'd5) ? 3'd0 : rng, en, en ? code : 5'd0});
        conv_result_i <= r;
        conv_valid_i <= 1'b1;
        @(posedge clock_i);
        conv_valid_i <= 1'b0;
    endtask

    task automatic zeros();
        {pat, dsel, rng, en, code} = '0;
        foreach (map[i]) rd(map[i], 32'h0, POM_RESP_OKAY);
        conv(16'h1234);
    endtask

    always @(posedge clock_i) begin
        if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) begin
            if (wr_q.size() == 0) chk("spare bresp", 34'h0, 34'h1);
            else chk("bresp", {32'h0, wr_q.pop_front()}, {32'h0, s_axi_bresp});
        end
        if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
            if (rd_q.size() == 0) chk("spare rdata", 34'h0, 34'h1);
            else chk("rresp rdata", rd_q.pop_front(), {s_axi_rresp, s_axi_rdata});
        end
        if (out_valid_o === 1'b1) begin
            if (dp_q.size() == 0) chk("spare out", 34'h0, 34'h1);
            else chk("word range en offset", {9'h0, dp_q.pop_front()},
                     {9'h0, out_word_o, ref_range_o, margin_enable_o, margin_offset_o});
        end
    end

    initial begin
        repeat (100000) @(posedge clock_i);
        timeout();
    end

    initial begin
        logic [7:0] d;
        fails = 0;
        checks = 0;
        rst_i = 1'b1;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {conv_result_i, conv_valid_i} = '0;
        repeat (5) @(posedge clock_i);
        rst_i <= 1'b0;
        void'($urandom(32'h7dcf));
        zeros();
        rd(12'h100, 32'h0, POM_RESP_SLVERR);
        wr(12'h059, 32'hff, 4'hf, POM_RESP_SLVERR);
        for (int i = 3; i < 6; i++) begin
            put(map[i], 8'hff);
            rd(map[i], shadow(map[i]), POM_RESP_OKAY);
        end
        for (int i = 0; i < 16; i++) begin
            d = $urandom_range(1, 5);
            put(map[d], 8'($urandom()));
            rd(map[d], (d == 2) ? {24'h0, s_axi_wdata[7:0]} : shadow(map[d]), POM_RESP_OKAY);
        end
        put(12'h054, 8'h00);
        rd(12'h054, 32'h0, POM_RESP_OKAY);
        wr(12'h058, 32'h5, 4'h0, POM_RESP_OKAY);
        rd(12'h058, shadow(12'h058), POM_RESP_OKAY);
        for (int k = 0; k < 8; k++) begin
            put(12'h080, 8'(k));
            conv(16'($urandom()));
        end
        for (int k = 0; k < 32; k++) begin
            d = $urandom();
            d[4:0] = 5'(k);
            put(12'h0c0, d);
            conv(16'($urandom()));
        end
        put(12'h050, 8'($urandom()));
        put(12'h058, 8'($urandom()));
        put(12'h040, 8'h01);
        conv(16'($urandom()));
        conv(16'($urandom()));
        put(12'h040, 8'h00);
        conv(16'($urandom()));
        @(posedge clock_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clock_i);
        rst_i <= 1'b0;
        zeros();
        repeat (5) @(posedge clock_i);
        chk("queues left", 34'h0, 34'(rd_q.size() + wr_q.size() + dp_q.size()));
        final_report();
    end
endmodule

// ===== pom_cfg_if.sv
`timescale 1ns/100ps
interface pom_cfg_if;
    import pom_pkg::*;
    logic [POM_PAT_W-1:0]   pattern_word;
    logic                   output_data_select;
    logic [POM_RANGE_W-1:0] offset_calibration_range;
    logic                   margin_enable;
    logic [POM_CODE_W-1:0]  margin_offset_code;

    modport regs (
        output pattern_word,
        output output_data_select,
        output offset_calibration_range,
        output margin_enable,
        output margin_offset_code
    );
    modport dec (
        input pattern_word,
        input output_data_select,
        input offset_calibration_range,
        input margin_enable,
        input margin_offset_code
    );
endinterface

// ===== pom_decode.sv
`timescale 1ns/100ps
module pom_decode
    import pom_pkg::*;
(
    input  wire logic                   clock_i,
    input  wire logic                   rst_i,
    pom_cfg_if.dec                      cfg,
    input  wire logic [POM_PAT_W-1:0]   conv_result_i,
    input  wire logic                   conv_valid_i,
    output logic [POM_PAT_W-1:0]        out_word_o,
    output logic                        out_valid_o,
    output logic [POM_RANGE_W-1:0]      ref_range_o,
    output logic                        margin_enable_o,
    output logic signed [POM_CODE_W-1:0] margin_offset_o
);
    pom_ref_range_t nxt_range;

    // range codes above the table fall back to the 5.0 v setting
    always_comb begin
        unique case (cfg.offset_calibration_range)
            3'b001:  nxt_range = POM_REF_4V5;
            3'b010:  nxt_range = POM_REF_4V096;
            3'b011:  nxt_range = POM_REF_3V3;
            3'b100:  nxt_range = POM_REF_3V0;
            3'b101:  nxt_range = POM_REF_2V5;
            default: nxt_range = POM_REF_5V0;
        endcase
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            ref_range_o <= POM_RST_RANGE;
        end else begin
            ref_range_o <= nxt_range;
        end
    end

    // margin shift is the signed code, zero while disabled
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            margin_enable_o <= POM_RST_BIT;
            margin_offset_o <= POM_RST_CODE;
        end else begin
            margin_enable_o <= cfg.margin_enable;
            margin_offset_o <= cfg.margin_enable ?
                               $signed(cfg.margin_offset_code) : POM_RST_CODE;
        end
    end

    // output word: conversion result or fixed pattern
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            out_word_o  <= '0;
            out_valid_o <= 1'b0;
        end else begin
            out_valid_o <= conv_valid_i;
            if (conv_valid_i) begin
                out_word_o <= cfg.output_data_select ? cfg.pattern_word
                                                     : conv_result_i;
            end
        end
    end

    sequence s_pat_sample;
        conv_valid_i && cfg.output_data_select;
    endsequence

    a_range_alias: assert property (@(posedge clock_i) disable iff (rst_i)
        cfg.offset_calibration_range > 3'b101 |=> ref_range_o == 3'b000)
        else $error("range code above table not aliased to 5.0 v");
    a_range_pass: assert property (@(posedge clock_i) disable iff (rst_i)
        cfg.offset_calibration_range <= 3'b101 |=>
        ref_range_o == $past(cfg.offset_calibration_range))
        else $error("range code not passed through");
    a_margin_off: assert property (@(posedge clock_i) disable iff (rst_i)
        !cfg.margin_enable |=> !margin_enable_o && margin_offset_o == 5'sh00)
        else $error("margin active while disabled");
    a_margin_sign: assert property (@(posedge clock_i) disable iff (rst_i)
        cfg.margin_enable |=> margin_enable_o &&
        margin_offset_o == $signed($past(cfg.margin_offset_code)))
        else $error("margin shift does not follow code");
    a_pattern_sub: assert property (@(posedge clock_i) disable iff (rst_i)
        s_pat_sample |=> out_valid_o && out_word_o == $past(cfg.pattern_word))
        else $error("pattern not substituted for result");
endmodule

// ===== pom_pkg.sv
package pom_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] POM_IDX_DATA_SEL = 8'h10;
    localparam logic [7:0] POM_IDX_PAT_LOW  = 8'h14;
    localparam logic [7:0] POM_IDX_PAT_MID  = 8'h15;
    localparam logic [7:0] POM_IDX_PAT_TOP  = 8'h16;
    localparam logic [7:0] POM_IDX_OFST     = 8'h20;
    localparam logic [7:0] POM_IDX_MARGIN   = 8'h30;

    // field widths and positions
    localparam int POM_TOP_W      = 4;
    localparam int POM_RANGE_W    = 3;
    localparam int POM_CODE_W     = 5;
    localparam int POM_MARG_EN_BIT = 5;
    localparam int POM_PAT_W      = 16;

    // reset values
    localparam logic [7:0]           POM_RST_BYTE     = 8'h00;
    localparam logic [POM_TOP_W-1:0] POM_RST_TOP      = 4'h0;
    localparam logic [2:0]           POM_RST_RANGE    = 3'h0;
    localparam logic [4:0]           POM_RST_CODE     = 5'h00;
    localparam logic                 POM_RST_BIT      = 1'b0;

    // axi responses
    localparam logic [1:0] POM_RESP_OKAY   = 2'h0;
    localparam logic [1:0] POM_RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        POM_REF_5V0   = 3'b000,
        POM_REF_4V5   = 3'b001,
        POM_REF_4V096 = 3'b010,
        POM_REF_3V3   = 3'b011,
        POM_REF_3V0   = 3'b100,
        POM_REF_2V5   = 3'b101
    } pom_ref_range_t;
endpackage

// ===== pom_regs.sv
`timescale 1ns/100ps
// Notes on behaviour
// - pattern top four bits stored, read/write
// - pattern register bits 7..4 read zero
// - range codes 0..5 pick 5.0 to 2.5 v
// - range codes 6 and 7 act as 5.0 v
// - offset register bits 7..3 read zero
// - bit 5 enables reference margining
// - five-bit margin code is two's complement
// - margin register bits 7..6 read zero
// - registers at 016h, 020h, 030h reset zero
// - data select swaps result for pattern
module pom_regs
    import pom_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input  wire logic                    clock_i,
    input  wire logic                    rst_i,
    input  wire logic [ADDR_W-1:0]       s_axi_awaddr,
    input  wire logic                    s_axi_awvalid,
    output logic                         s_axi_awready,
    input  wire logic [31:0]             s_axi_wdata,
    input  wire logic [3:0]              s_axi_wstrb,
    input  wire logic                    s_axi_wvalid,
    output logic                         s_axi_wready,
    output logic [1:0]                   s_axi_bresp,
    output logic                         s_axi_bvalid,
    input  wire logic                    s_axi_bready,
    input  wire logic [ADDR_W-1:0]       s_axi_araddr,
    input  wire logic                    s_axi_arvalid,
    output logic                         s_axi_arready,
    output logic [31:0]                  s_axi_rdata,
    output logic [1:0]                   s_axi_rresp,
    output logic                         s_axi_rvalid,
    input  wire logic                    s_axi_rready,
    input  wire logic [POM_PAT_W-1:0]    conv_result_i,
    input  wire logic                    conv_valid_i,
    output logic [POM_PAT_W-1:0]         out_word_o,
    output logic                         out_valid_o,
    output logic [POM_RANGE_W-1:0]       ref_range_o,
    output logic                         margin_enable_o,
    output logic signed [POM_CODE_W-1:0] margin_offset_o
);
    pom_cfg_if cfg ();

    logic [ADDR_W-1:0]      wr_addr_ff;
    logic [31:0]            wr_data_ff;
    logic [3:0]             wr_strb_ff;
    logic                   aw_ok_ff;
    logic                   w_ok_ff;
    logic                   bvalid_ff;
    logic [1:0]             bresp_ff;
    logic [ADDR_W-1:0]      rd_addr_ff;
    logic                   rvalid_ff;
    logic [31:0]            rdata_ff;
    logic [1:0]             rresp_ff;
    logic                   data_sel_ff;
    logic [7:0]             pat_low_ff;
    logic [7:0]             pat_mid_ff;
    logic [POM_TOP_W-1:0]   pat_top_ff;
    logic [POM_RANGE_W-1:0] range_ff;
    logic                   marg_en_ff;
    logic [POM_CODE_W-1:0]  marg_code_ff;
    logic                   wr_go;
    logic                   wr_hit;
    logic [7:0]             wr_idx;
    logic                   lane0;
    logic [32:0]            rd_look;

    function automatic logic [32:0] rd_lookup(input logic [ADDR_W-1:0] a);
        logic [32:0] r;
        r = {1'b0, 32'h0000_0000};
        if (a[ADDR_W-1:10] == '0 && a[1:0] == 2'b00) begin
            unique case (a[9:2])
                POM_IDX_DATA_SEL: r = {1'b1, 31'h0000_0000, data_sel_ff};
                POM_IDX_PAT_LOW:  r = {1'b1, 24'h00_0000, pat_low_ff};
                POM_IDX_PAT_MID:  r = {1'b1, 24'h00_0000, pat_mid_ff};
                POM_IDX_PAT_TOP:  r = {1'b1, 28'h000_0000, pat_top_ff};
                POM_IDX_OFST:     r = {1'b1, 29'h0000_0000, range_ff};
                POM_IDX_MARGIN:   r = {1'b1, 26'h000_0000, marg_en_ff,
                                       marg_code_ff};
                default:          r = {1'b0, 32'h0000_0000};
            endcase
        end
        return r;
    endfunction

    assign s_axi_awready = !aw_ok_ff && !bvalid_ff;
    assign s_axi_wready  = !w_ok_ff && !bvalid_ff;
    assign s_axi_arready = !rvalid_ff;
    assign s_axi_bvalid  = bvalid_ff;
    assign s_axi_bresp   = bresp_ff;
    assign s_axi_rvalid  = rvalid_ff;
    assign s_axi_rdata   = rdata_ff;
    assign s_axi_rresp   = rresp_ff;

    assign wr_go   = aw_ok_ff && w_ok_ff && !bvalid_ff;
    assign wr_idx  = wr_addr_ff[9:2];
    assign wr_hit  = rd_lookup(wr_addr_ff) >> 32 != 33'h0;
    assign lane0   = wr_go && wr_hit && wr_strb_ff[0];

    // function body reads the registers, so a process keeps it fresh
    always_comb begin
        rd_look = rd_lookup(s_axi_araddr);
    end

    // write address and data captured in either order
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            aw_ok_ff   <= 1'b0;
            wr_addr_ff <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_ok_ff   <= 1'b1;
            wr_addr_ff <= s_axi_awaddr;
        end else if (wr_go) begin
            aw_ok_ff   <= 1'b0;
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            w_ok_ff    <= 1'b0;
            wr_data_ff <= 32'h0000_0000;
            wr_strb_ff <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_ok_ff    <= 1'b1;
            wr_data_ff <= s_axi_wdata;
            wr_strb_ff <= s_axi_wstrb;
        end else if (wr_go) begin
            w_ok_ff    <= 1'b0;
        end
    end

    // write response, slverr for unmapped addresses
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            bvalid_ff <= 1'b0;
            bresp_ff  <= POM_RESP_OKAY;
        end else if (wr_go) begin
            bvalid_ff <= 1'b1;
            bresp_ff  <= wr_hit ? POM_RESP_OKAY : POM_RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_ff <= 1'b0;
        end
    end

    // read channel
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            rvalid_ff  <= 1'b0;
            rdata_ff   <= 32'h0000_0000;
            rresp_ff   <= POM_RESP_OKAY;
            rd_addr_ff <= '0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_ff  <= 1'b1;
            rdata_ff   <= rd_look[31:0];
            rresp_ff   <= rd_look[32] ? POM_RESP_OKAY : POM_RESP_SLVERR;
            rd_addr_ff <= s_axi_araddr;
        end else if (s_axi_rready) begin
            rvalid_ff  <= 1'b0;
        end
    end

    // pattern registers; only the low nibble of the top one is writable
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            pat_low_ff <= POM_RST_BYTE;
            pat_mid_ff <= POM_RST_BYTE;
            pat_top_ff <= POM_RST_TOP;
        end else if (lane0) begin
            if (wr_idx == POM_IDX_PAT_LOW) begin
                pat_low_ff <= wr_data_ff[7:0];
            end
            if (wr_idx == POM_IDX_PAT_MID) begin
                pat_mid_ff <= wr_data_ff[7:0];
            end
            if (wr_idx == POM_IDX_PAT_TOP) begin
                pat_top_ff <= wr_data_ff[POM_TOP_W-1:0];
            end
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            data_sel_ff <= POM_RST_BIT;
        end else if (lane0 && wr_idx == POM_IDX_DATA_SEL) begin
            data_sel_ff <= wr_data_ff[0];
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            range_ff <= POM_RST_RANGE;
        end else if (lane0 && wr_idx == POM_IDX_OFST) begin
            range_ff <= wr_data_ff[POM_RANGE_W-1:0];
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            marg_en_ff   <= POM_RST_BIT;
            marg_code_ff <= POM_RST_CODE;
        end else if (lane0 && wr_idx == POM_IDX_MARGIN) begin
            marg_en_ff   <= wr_data_ff[POM_MARG_EN_BIT];
            marg_code_ff <= wr_data_ff[POM_CODE_W-1:0];
        end
    end

    // top nibble on bits 15..12, low byte on 7..0, mid low nibble between
    assign cfg.pattern_word             = {pat_top_ff, pat_mid_ff[3:0], pat_low_ff};
    assign cfg.output_data_select       = data_sel_ff;
    assign cfg.offset_calibration_range = range_ff;
    assign cfg.margin_enable            = marg_en_ff;
    assign cfg.margin_offset_code       = marg_code_ff;

    pom_decode u_decode (
        .clock_i         (clock_i),
        .rst_i           (rst_i),
        .cfg             (cfg.dec),
        .conv_result_i   (conv_result_i),
        .conv_valid_i    (conv_valid_i),
        .out_word_o      (out_word_o),
        .out_valid_o     (out_valid_o),
        .ref_range_o     (ref_range_o),
        .margin_enable_o (margin_enable_o),
        .margin_offset_o (margin_offset_o)
    );

    a_pattern_store: assert property (@(posedge clock_i) disable iff (rst_i)
        lane0 && wr_idx == POM_IDX_PAT_TOP |=> pat_top_ff == $past(wr_data_ff[3:0]))
        else $error("pattern top bits not stored");
    a_pattern_resv: assert property (@(posedge clock_i) disable iff (rst_i)
        rvalid_ff && rd_addr_ff == ADDR_W'({POM_IDX_PAT_TOP, 2'b00})
        |-> rdata_ff[31:4] == 28'h000_0000)
        else $error("pattern reserved bits read nonzero");
    a_ofst_resv: assert property (@(posedge clock_i) disable iff (rst_i)
        rvalid_ff && rd_addr_ff == ADDR_W'({POM_IDX_OFST, 2'b00})
        |-> rdata_ff[31:3] == 29'h0000_0000)
        else $error("offset reserved bits read nonzero");
    a_margin_resv: assert property (@(posedge clock_i) disable iff (rst_i)
        rvalid_ff && rd_addr_ff == ADDR_W'({POM_IDX_MARGIN, 2'b00})
        |-> rdata_ff[31:6] == 26'h000_0000)
        else $error("margin reserved bits read nonzero");
    a_reset_clear: assert property (@(posedge clock_i)
        $past(rst_i) && !rst_i |-> pat_top_ff == 4'h0 && range_ff == 3'h0
        && !marg_en_ff && marg_code_ff == 5'h00)
        else $error("registers not cleared by reset");
    a_write_scope: assert property (@(posedge clock_i) disable iff (rst_i)
        wr_go && wr_idx == POM_IDX_PAT_TOP |=> $stable(range_ff) && $stable(marg_en_ff)
        && $stable(marg_code_ff))
        else $error("write disturbed another register");
    a_margin_bit: assert property (@(posedge clock_i) disable iff (rst_i)
        lane0 && wr_idx == POM_IDX_MARGIN |=> marg_en_ff == $past(wr_data_ff[5]) ##1
        margin_enable_o == $past(marg_en_ff))
        else $error("margin enable not taken from bit 5");
    a_write_resp: assert property (@(posedge clock_i) disable iff (rst_i)
        wr_go |=> s_axi_bvalid)
        else $error("write response missing");

    sequence s_wr_commit;
        wr_go && wr_hit;
    endsequence

    sequence s_rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence

    a_hit_okay: assert property (@(posedge clock_i) disable iff (rst_i)
        s_wr_commit |=> s_axi_bresp == POM_RESP_OKAY)
        else $error("mapped write not answered okay");
    a_miss_err: assert property (@(posedge clock_i) disable iff (rst_i)
        wr_go && !wr_hit |=> s_axi_bresp == POM_RESP_SLVERR)
        else $error("unmapped write not flagged");
    a_rd_answer: assert property (@(posedge clock_i) disable iff (rst_i)
        s_rd_take |=> s_axi_rvalid)
        else $error("read answer missing");
    a_b_clear: assert property (@(posedge clock_i) disable iff (rst_i)
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response not released");
    a_r_clear: assert property (@(posedge clock_i) disable iff (rst_i)
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read response not released");
    a_aw_block: assert property (@(posedge clock_i) disable iff (rst_i)
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");
    a_ar_block: assert property (@(posedge clock_i) disable iff (rst_i)
        s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while answer pending");
    a_ofst_store: assert property (@(posedge clock_i) disable iff (rst_i)
        lane0 && wr_idx == POM_IDX_OFST |=> range_ff == $past(wr_data_ff[POM_RANGE_W-1:0]))
        else $error("range code not stored");
    a_code_store: assert property (@(posedge clock_i) disable iff (rst_i)
        lane0 && wr_idx == POM_IDX_MARGIN |=> marg_code_ff == $past(wr_data_ff[POM_CODE_W-1:0]))
        else $error("margin code not stored");
    a_dsel_store: assert property (@(posedge clock_i) disable iff (rst_i)
        lane0 && wr_idx == POM_IDX_DATA_SEL |=> data_sel_ff == $past(wr_data_ff[0]))
        else $error("data select not stored");
    a_strb_guard: assert property (@(posedge clock_i) disable iff (rst_i)
        wr_go && !wr_strb_ff[0] |=> $stable(pat_top_ff) && $stable(range_ff)
        && $stable(marg_en_ff) && $stable(marg_code_ff) && $stable(data_sel_ff))
        else $error("write without lane 0 changed a register");
endmodule
